// ---- rtl/lcdl_consts.svh ----
`ifndef LCDL_CONSTS_SVH
`define LCDL_CONSTS_SVH
// Bus address of the loader (seven bits)
`define LCDL_SLAVE_ADDR 7'h38
// Display memory geometry
`define LCDL_RAM_WORDS 6'h23
`define LCDL_RAM_BITS 4
// Drive mode codes held in the mode field
`define LCDL_MODE_1TO4 2'h0
`define LCDL_MODE_STATIC 2'h1
`define LCDL_MODE_1TO2 2'h2
`define LCDL_MODE_1TO3 2'h3
// Command byte fields
`define LCDL_CONT_BIT 7
`define LCDL_OP_MODE 2'h2
`define LCDL_OP_SELECT 4'hc
`define LCDL_OP_BLINK 4'he
`define LCDL_OP_SLEEP 4'hf
// Reset values
`define LCDL_RST_MODE 2'h0
`define LCDL_RST_PTR 6'h00
`define LCDL_RST_SUB 3'h0
`define LCDL_RST_BLINK 3'h0
// Bit count of one byte on the wire
`define LCDL_BYTE_BITS 4'h8
`endif

// ---- rtl/lcdl_pkg.sv ----
package lcdl_pkg;
  typedef enum logic [2:0] {
    LCDL_IDLE, LCDL_ADDR, LCDL_CMD, LCDL_DATA, LCDL_SKIP
  } lcdl_phase_type;
  typedef enum logic [2:0] {
    LCDL_C_NONE, LCDL_C_MODE, LCDL_C_PTR, LCDL_C_BLINK, LCDL_C_SLEEP,
    LCDL_C_SELECT
  } lcdl_cmd_type;
endpackage

// ---- rtl/lcdl_ram.sv ----
`timescale 1ns/1ns
`include "lcdl_consts.svh"
module lcdl_ram import lcdl_pkg::*; #(
  parameter int WORDS = 35,
  parameter int BITS = 4
) (
  input wire logic clk, // System clock
  input wire logic we, // Write strobe
  input wire logic [5:0] waddr, // Write word address
  input wire logic [BITS-1:0] wdata, // Write data
  input wire logic [BITS-1:0] wmask, // Bits that take wdata
  input wire logic [5:0] raddr, // Read word address
  output logic [BITS-1:0] rdata // Registered read data
);
  // One bit-plane per backplane, so each plane has a single writer;
  // no reset, display content is undefined at power up
  genvar b;
  generate
    for (b = 0; b < BITS; b++) begin : g_bit
      logic plane [WORDS]; // One bit of every word
      // Masked write so uncovered bits keep their value
      always_ff @(posedge clk) begin
        if (we && waddr < 6'(WORDS) && wmask[b]) begin
          plane[waddr] <= wdata[b];
        end
      end
      // Registered read, out of range reads as zero
      always_ff @(posedge clk) begin
        if (raddr < 6'(WORDS)) begin
          rdata[b] <= plane[raddr];
        end else begin
          rdata[b] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // lcdl_ram

// ---- rtl/lcdl_top.sv ----
`timescale 1ns/1ns
`include "lcdl_consts.svh"
module lcdl_top import lcdl_pkg::*; #(
  parameter int RAM_WORDS = 35,
  parameter int RAM_BITS = 4
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic scl_in, // Bus clock level
  input wire logic sda_in, // Bus data level
  output logic sda_out, // Bus data drive value
  output logic sda_oe_n, // Low while driving data
  input wire logic [2:0] hw_subaddr, // Strapped sub-address
  input wire logic [5:0] disp_addr, // Display scan word address
  output logic [3:0] disp_data, // Display word, 1 = segment on
  output logic [1:0] mux_mode, // Drive mode code
  output logic bias_third, // Bias selection bit
  output logic display_on, // Display enabled and awake
  output logic display_clk_run, // Display clock allowed
  output logic [2:0] blink_mode, // Blink setting
  output lcdl_cmd_type cmd_type, // Last decoded command
  output logic [5:0] data_ptr, // Current data pointer
  output logic sleeping // Sleep state
);
  typedef struct packed {
    lcdl_phase_type phase; // Transfer phase
    logic scl_q; // Previous bus clock
    logic sda_q; // Previous bus data
    logic [7:0] shift; // Receive shifter
    logic [3:0] bitcnt; // Bits in current byte
    logic ack_want; // Acknowledge this byte
    logic ack_on; // Inside acknowledge bit
    logic sda_out; // Pin value
    logic sda_oe_n; // Pin enable, low drives
    logic [1:0] mode; // Drive mode
    logic bias; // Bias bit
    logic enable; // Display enable
    logic [2:0] blink; // Blink setting
    logic [5:0] ptr; // Data pointer
    logic [2:0] sub_sel; // Selected sub-address
    logic sleep_req; // Sleep bit from command
    logic sleeping; // Sleep state
    lcdl_cmd_type cmd; // Last command
    logic wr_act; // Byte spread in progress
    logic [2:0] wr_idx; // Word within byte
    logic [7:0] wr_byte; // Byte being spread
    logic [5:0] wr_base; // Pointer at byte start
    logic ram_we; // Memory write strobe
    logic [5:0] ram_addr; // Memory word
    logic [3:0] ram_data; // Memory data
    logic [3:0] ram_mask; // Memory bit mask
    logic disp_on; // Display on output
    logic clk_run; // Display clock allowed
  } lcdl_state_type;

  lcdl_state_type st_reg, st_next;
  logic [3:0] rd_data; // Registered display word

  // Bits per word for a mode; used by pack, words_per_byte has its own table
  function automatic logic [2:0] bits_per_word(input logic [1:0] m);
    case (m)
      `LCDL_MODE_STATIC: bits_per_word = 3'h1;
      `LCDL_MODE_1TO2: bits_per_word = 3'h2;
      `LCDL_MODE_1TO3: bits_per_word = 3'h3;
      default: bits_per_word = 3'h4;
    endcase
  endfunction

  // Words one byte occupies in a mode
  function automatic logic [2:0] words_per_byte(input logic [1:0] m);
    case (m)
      `LCDL_MODE_STATIC: words_per_byte = 3'h0; // 8, wraps to 0
      `LCDL_MODE_1TO2: words_per_byte = 3'h4;
      `LCDL_MODE_1TO3: words_per_byte = 3'h3;
      default: words_per_byte = 3'h2;
    endcase
  endfunction

  // Mask and data for word w: byte bits taken MSB first, column-wise
  function automatic logic [7:0] pack(input logic [7:0] b,
                                      input logic [2:0] k,
                                      input logic [2:0] w);
    logic [2:0] col;
    logic [2:0] row;
    logic [3:0] m;
    logic [3:0] d;
    col = 3'h0;
    row = 3'h0;
    m = 4'h0;
    d = 4'h0;
    for (int j = 7; j >= 0; j--) begin
      if (col == w) begin
        m[row[1:0]] = 1'b1;
        d[row[1:0]] = b[j];
      end
      if (row == k - 3'h1) begin
        row = 3'h0;
        col = col + 3'h1;
      end else begin
        row = row + 3'h1;
      end
    end
    pack = {m, d};
  endfunction

  // Pointer step with wrap inside the memory
  function automatic logic [5:0] step_ptr(input logic [5:0] p,
                                          input logic [1:0] m);
    logic [6:0] s;
    s = {1'b0, p} + ((m == `LCDL_MODE_STATIC) ? 7'h08 :
        {4'h0, words_per_byte(m)});
    if (s >= {1'b0, `LCDL_RAM_WORDS}) begin
      s = s - {1'b0, `LCDL_RAM_WORDS};
    end
    step_ptr = s[5:0];
  endfunction

  // Whole next-state logic
  always_comb begin
    logic start_c;
    logic stop_c;
    logic rise;
    logic fall;
    logic [7:0] b;
    logic [7:0] pk;
    logic [2:0] last_w;
    st_next = st_reg;
    start_c = st_reg.scl_q && scl_in && st_reg.sda_q && !sda_in;
    stop_c = st_reg.scl_q && scl_in && !st_reg.sda_q && sda_in;
    rise = !st_reg.scl_q && scl_in;
    fall = st_reg.scl_q && !scl_in;
    b = {st_reg.shift[6:0], sda_in};
    pk = 8'h00;
    last_w = 3'h0;
    st_next.scl_q = scl_in;
    st_next.sda_q = sda_in;
    st_next.ram_we = 1'b0;
    // Spread a data byte over its words, one word per cycle
    if (st_reg.wr_act) begin
      pk = pack(st_reg.wr_byte, bits_per_word(st_reg.mode),
                st_reg.wr_idx);
      st_next.ram_we = 1'b1;
      st_next.ram_addr = st_reg.wr_base + {3'h0, st_reg.wr_idx};
      st_next.ram_mask = pk[7:4];
      st_next.ram_data = pk[3:0];
      last_w = words_per_byte(st_reg.mode) - 3'h1;
      st_next.wr_idx = st_reg.wr_idx + 3'h1;
      if (st_reg.wr_idx == last_w) begin
        st_next.wr_act = 1'b0;
      end
    end
    if (start_c) begin
      // Start or repeated start: expect an address
      st_next.phase = LCDL_ADDR;
      st_next.bitcnt = 4'h0;
      st_next.ack_on = 1'b0;
      st_next.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      // Transfer ends; pending sleep now takes hold
      st_next.phase = LCDL_IDLE;
      st_next.sda_oe_n = 1'b1;
      if (st_reg.phase != LCDL_IDLE && st_reg.sleep_req) begin
        st_next.sleeping = 1'b1;
      end
    end else if (st_reg.phase == LCDL_IDLE ||
                 st_reg.phase == LCDL_SKIP) begin
      st_next.sda_oe_n = 1'b1;
    end else if (rise && st_reg.bitcnt != `LCDL_BYTE_BITS) begin
      st_next.shift = b;
      st_next.bitcnt = st_reg.bitcnt + 4'h1;
      if (st_reg.bitcnt == `LCDL_BYTE_BITS - 4'h1) begin
        st_next.ack_want = 1'b1;
        if (st_reg.phase == LCDL_ADDR) begin
          // Only a write to our address is answered
          if (b[7:1] == `LCDL_SLAVE_ADDR && !b[0]) begin
            st_next.phase = LCDL_CMD;
          end else begin
            st_next.ack_want = 1'b0;
          end
        end else if (st_reg.phase == LCDL_CMD) begin
          st_next.sleeping = 1'b0;
          if (!b[`LCDL_CONT_BIT]) begin
            st_next.phase = LCDL_DATA;
          end
          // Command decode
          if (!b[6]) begin
            st_next.cmd = LCDL_C_PTR;
            st_next.ptr = b[5:0];
          end else if (b[6:5] == `LCDL_OP_MODE) begin
            st_next.cmd = LCDL_C_MODE;
            st_next.enable = b[3];
            st_next.bias = b[2];
            st_next.mode = b[1:0];
          end else if (b[6:3] == `LCDL_OP_SELECT) begin
            st_next.cmd = LCDL_C_SELECT;
            st_next.sub_sel = b[2:0];
          end else if (b[6:3] == `LCDL_OP_BLINK) begin
            st_next.cmd = LCDL_C_BLINK;
            st_next.blink = b[2:0];
          end else if (b[6:3] == `LCDL_OP_SLEEP) begin
            st_next.cmd = LCDL_C_SLEEP;
            st_next.sleep_req = b[0];
          end else begin
            st_next.cmd = LCDL_C_NONE; // Unused code, still acked
          end
        end else if (st_reg.sub_sel == hw_subaddr) begin
          // Data byte for this device; step pointer as the spread starts
          st_next.wr_act = 1'b1;
          st_next.wr_idx = 3'h0;
          st_next.wr_byte = b;
          st_next.wr_base = st_reg.ptr;
          st_next.ptr = step_ptr(st_reg.ptr, st_reg.mode);
        end
      end
    end else if (fall && st_reg.bitcnt == `LCDL_BYTE_BITS) begin
      if (!st_reg.ack_on) begin
        // Acknowledge slot opens
        st_next.ack_on = 1'b1;
        st_next.sda_out = 1'b0;
        st_next.sda_oe_n = !st_reg.ack_want;
      end else begin
        // Slot over; release the line
        st_next.ack_on = 1'b0;
        st_next.sda_oe_n = 1'b1;
        st_next.bitcnt = 4'h0;
        if (!st_reg.ack_want) begin
          st_next.phase = LCDL_SKIP;
        end
      end
    end
    // Blank and stop display clock while asleep
    st_next.disp_on = st_next.enable && !st_next.sleeping;
    st_next.clk_run = !st_next.sleeping;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0; // Idle phase and no command are the zero codes
      st_reg.scl_q <= 1'b1;
      st_reg.sda_q <= 1'b1;
      st_reg.sda_out <= 1'b1;
      st_reg.sda_oe_n <= 1'b1;
      st_reg.mode <= `LCDL_RST_MODE;
      st_reg.ptr <= `LCDL_RST_PTR;
      st_reg.sub_sel <= `LCDL_RST_SUB;
      st_reg.blink <= `LCDL_RST_BLINK;
      st_reg.clk_run <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  // Display memory, 35 x 4
  lcdl_ram #(
    .WORDS(RAM_WORDS),
    .BITS(RAM_BITS)
  ) u_ram (
    .clk(mclk),
    .we(st_reg.ram_we),
    .waddr(st_reg.ram_addr),
    .wdata(st_reg.ram_data),
    .wmask(st_reg.ram_mask),
    .raddr(disp_addr),
    .rdata(rd_data)
  );

  // Outputs straight from flops
  assign sda_out = st_reg.sda_out;
  assign sda_oe_n = st_reg.sda_oe_n;
  assign disp_data = rd_data;
  assign mux_mode = st_reg.mode;
  assign bias_third = st_reg.bias;
  assign display_on = st_reg.disp_on;
  assign display_clk_run = st_reg.clk_run;
  assign blink_mode = st_reg.blink;
  assign cmd_type = st_reg.cmd;
  assign data_ptr = st_reg.ptr;
  assign sleeping = st_reg.sleeping;
endmodule // lcdl_top

// ---- sim/lcdl_bus_master.sv ----
`timescale 1ns/1ns
module lcdl_bus_master (
  input wire logic mclk, // System clock
  input wire logic sda, // Resolved data wire
  input wire logic slow, // Device asleep, bus rate halved
  output logic scl, // Bus clock
  output logic sda_drv // Data drive, 0 pulls low
);
  // Bus clock high time in mclk cycles, a third of a bit period, well above the oversampling need
  localparam int HALF = 6;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Bus clock kept slower while the device is saving power
  task automatic tick();
    repeat (slow ? 2 * HALF : HALF) @(negedge mclk);
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    tick();
    sda_drv = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_drv = 1'b0;
    tick();
    scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    tick();
    sda_drv = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_drv = 1'b1;
    tick();
  endtask
  // Eight bits MSB first, then a released ninth slot for the ack
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic [8:0] v;
    v = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      tick();
      sda_drv = v[i];
      tick();
      scl = 1'b1;
      tick();
      ack = sda;
      scl = 1'b0;
    end
  endtask
endmodule // lcdl_bus_master

// ---- sim/lcdl_properties.sv ----
`timescale 1ns/1ns
module lcdl_properties import lcdl_pkg::*; (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic scl_in, // Bus clock level
  input wire logic sda_in, // Bus data level
  input wire logic sda_out, // Data drive value
  input wire logic sda_oe_n, // Data drive enable, low
  input wire logic [1:0] mux_mode, // Drive mode
  input wire logic display_on, // Display enabled
  input wire logic display_clk_run, // Display clock allowed
  input wire logic [2:0] blink_mode, // Blink setting
  input wire lcdl_cmd_type cmd_type, // Last command
  input wire logic [5:0] data_ptr, // Data pointer
  input wire logic sleeping // Sleep state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Words one display byte occupies in the current mode
  logic [6:0] ptr_step;
  assign ptr_step = (mux_mode == 2'h0) ? 7'h2 : (mux_mode == 2'h1) ? 7'h8 :
    (mux_mode == 2'h2) ? 7'h4 : 7'h3;
  // Both bus lines were high: a stop has just been seen
  sequence s_bus_free;
    $past(scl_in) && $past(sda_in);
  endsequence
  property p_ack_low; !sda_oe_n |-> !sda_out; endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("ack drive not low");
  // Drive may only switch while the bus clock is low
  property p_ack_edge; $changed(sda_oe_n) |-> !$past(scl_in); endproperty
  a_ack_edge: assert property (p_ack_edge)
    else $error("ack switched with clock high");
  property p_awake_on; display_on |-> !sleeping && display_clk_run;
  endproperty
  a_awake_on: assert property (p_awake_on)
    else $error("display on while asleep");
  property p_sleep_clk; sleeping |-> !display_clk_run; endproperty
  a_sleep_clk: assert property (p_sleep_clk)
    else $error("display clock runs in sleep");
  property p_sleep_stop; $rose(sleeping) |-> s_bus_free; endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("sleep entered outside a stop");
  property p_wake; $fell(sleeping) |-> $past(scl_in); endproperty
  a_wake: assert property (p_wake)
    else $error("wake not on a received bit");
  property p_ptr_range; data_ptr < 6'h23; endproperty
  a_ptr_range: assert property (p_ptr_range)
    else $error("pointer beyond memory");
  property p_ptr_step;
    $changed(data_ptr) && cmd_type != LCDL_C_PTR |->
      7'(data_ptr) == (7'($past(data_ptr)) + ptr_step) % 7'h23;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer step wrong");
  property p_mode_src; $changed(mux_mode) |-> cmd_type == LCDL_C_MODE;
  endproperty
  a_mode_src: assert property (p_mode_src)
    else $error("mode changed without mode set");
  property p_blink_src; $changed(blink_mode) |-> cmd_type == LCDL_C_BLINK;
  endproperty
  a_blink_src: assert property (p_blink_src)
    else $error("blink changed without command");
endmodule // lcdl_properties
bind lcdl_top lcdl_properties i_lcdl_properties (.mclk(mclk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .mux_mode(mux_mode), .display_on(display_on),
  .display_clk_run(display_clk_run), .blink_mode(blink_mode),
  .cmd_type(cmd_type), .data_ptr(data_ptr), .sleeping(sleeping));

// ---- sim/tb_lcdl_top.sv ----
`timescale 1ns/1ns
module tb_lcdl_top import lcdl_pkg::*;;
  logic mclk, rst, scl, drv, sda, sda_out, sda_oe_n; // Bus and clocks
  logic [2:0] hw_subaddr, blink_mode; // Strap and blink
  logic [5:0] disp_addr, data_ptr; // Scan address, pointer
  logic [3:0] disp_data; // Scanned word
  logic [1:0] mux_mode; // Drive mode
  logic bias_third, display_on, display_clk_run, sleeping, a; // Status
  lcdl_cmd_type cmd_type; // Decoded command
  logic [3:0] mem [35]; // Expected memory
  logic [7:0] lfsr_reg = 8'h23; // Random source, seed 35
  int ptr, check_count, n_mismatch; // Expected pointer, counters
  // Open-drain wire with pull-up
  assign sda = drv & (sda_oe_n | sda_out);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  lcdl_top i_lcdl_top (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hw_subaddr(hw_subaddr),
    .disp_addr(disp_addr), .disp_data(disp_data), .mux_mode(mux_mode),
    .bias_third(bias_third), .display_on(display_on),
    .display_clk_run(display_clk_run), .blink_mode(blink_mode),
    .cmd_type(cmd_type), .data_ptr(data_ptr), .sleeping(sleeping));
  lcdl_bus_master i_lcdl_bus_master (.mclk(mclk), .sda(sda),
    .slow(sleeping), .scl(scl), .sda_drv(drv));
  function automatic logic [7:0] rnd();
    lfsr_reg = {lfsr_reg[6:0], ^(lfsr_reg & 8'hb8)};
    return lfsr_reg;
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Command byte: acked, then decoded into its type
  task automatic cmd(input logic [7:0] b, input lcdl_cmd_type t);
    i_lcdl_bus_master.wbyte(b, a);
    chk("ack", 8'h0, {7'h0, a});
    chk("cmd_type", 8'(t), 8'(cmd_type));
  endtask
  // Byte spread MSB first over words, k bits a word; k=0 code means 4
  task automatic put(input logic [7:0] d, input logic [1:0] m);
    int k;
    k = (m == 2'h0) ? 4 : int'(m);
    for (int j = 0; j < 8; j++)
      if (ptr + j / k < 35) mem[ptr + j / k][j % k] = d[7 - j];
    ptr = (ptr + (8 + k - 1) / k) % 35;
  endtask
  // One full transfer: commands, n data bytes, stop, then readback
  task automatic xfer(input logic [1:0] m, input int p, input int n,
    input logic slp);
    logic [7:0] r;
    r = rnd();
    hw_subaddr = r[2:0];
    i_lcdl_bus_master.start();
    i_lcdl_bus_master.wbyte(8'h70, a);
    chk("addr ack", 8'h0, {7'h0, a});
    cmd(8'he0 | 8'(r[2:0]), LCDL_C_SELECT);
    cmd(8'he8, LCDL_C_NONE);
    cmd(8'hf0 | 8'(r[5:3]), LCDL_C_BLINK);
    chk("blink", 8'(r[5:3]), 8'(blink_mode));
    cmd(8'hc8 | {5'h0, r[6], m}, LCDL_C_MODE);
    chk("bias", {7'h0, r[6]}, {7'h0, bias_third});
    cmd(8'h80 | 8'(p), LCDL_C_PTR);
    cmd(8'h78 | 8'(slp), LCDL_C_SLEEP);
    ptr = p;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      i_lcdl_bus_master.wbyte(r, a);
      chk("data ack", 8'h0, {7'h0, a});
      put(r, m);
    end
    i_lcdl_bus_master.stop();
    chk("ptr", 8'(ptr), 8'(data_ptr));
    chk("mode", 8'(m), 8'(mux_mode));
    chk("sleep", {7'h0, slp}, {7'h0, sleeping});
    chk("on", {7'h0, !slp}, {7'h0, display_on});
    chk("clk", {7'h0, !slp}, {7'h0, display_clk_run});
    for (int w = 0; w < 35; w++) begin
      disp_addr = 6'(w);
      repeat (2) @(negedge mclk);
      chk("word", 8'(mem[w]), 8'(disp_data));
    end
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    $display("wrong value run time expected end seen timeout");
    complete_run();
  end
  initial begin
    rst = 1'b1;
    disp_addr = 6'h00;
    hw_subaddr = 3'h0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    chk("rst ptr", 8'h00, 8'(data_ptr));
    chk("rst oe", 8'h01, {7'h0, sda_oe_n});
    chk("rst clk", 8'h01, {7'h0, display_clk_run});
    // Foreign address: no ack, rest ignored
    i_lcdl_bus_master.start();
    i_lcdl_bus_master.wbyte(8'h72, a);
    chk("nak", 8'h01, {7'h0, a});
    i_lcdl_bus_master.wbyte(8'h00, a);
    i_lcdl_bus_master.stop();
    xfer(2'h0, 0, 18, 1'b0); // Fill every word, pointer wraps
    for (int t = 0; t < 12; t++) begin
      lfsr_reg = rnd();
      xfer(lfsr_reg[1:0], 34 - t % 3 * 15, 1 + t % 5, t == 5);
    end
    complete_run();
  end
endmodule // tb_lcdl_top
